// file: sim/cmsr_regs_tb.sv
`timescale 1ns/1ps
module cmsr_regs_tb;
  import cmsr_pkg::*;

  // ==========================================================
  // stimulus and observation signals
  logic        clk_sys;
  logic        nrst;
  logic [3:0]  irq_level_req;
  logic        exc_req;
  logic        nmi_req;
  logic        scall_req;
  logic        event_ret;
  logic [31:0] event_ret_status;
  logic        dbg_enter;
  logic        dbg_return;
  logic        secure_enter;
  logic        secure_exit;
  logic        priv_instr;
  logic        cond_we;
  logic [4:0]  cond_flags;
  logic        rf_we;
  logic [3:0]  rf_widx;
  logic [31:0] rf_wdata;
  logic [3:0]  rf_ridx;
  logic        sysreg_req;
  logic        sysreg_write;
  logic [9:0]  sysreg_addr;
  logic [31:0] sysreg_wdata;
  logic [31:0] status_word;
  logic [31:0] rf_rdata;
  logic [31:0] sysreg_rdata;
  logic        sysreg_fault;
  logic        instr_fault;
  logic        event_taken;
  int          miscompares;
  int          cmp_count;
  logic [31:0] seed;
  logic [31:0] exp_sr;
  logic [31:0] sys_stack;
  logic [31:0] user_stack;
  logic [31:0] rf_model [16];

  cmsr_regs i_cmsr_regs (.*);

  // ==========================================================
  // clock, checking and closing
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // inputs move 1 ns after the edge, outputs are settled by then
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic ev(input logic [3:0] lvl, input logic e, input logic n,
                    input logic tk, input logic [2:0] md);
    irq_level_req = lvl;
    exc_req       = e;
    nmi_req       = n;
    tick();
    chk(event_taken, tk);
    chk(status_word[24:22], md);
  endtask : ev

  task automatic sra(input logic wr, input logic [9:0] addr, input logic [31:0] wd,
                     input logic [31:0] exp_rd, input logic exp_flt);
    sysreg_req   = 1'b1;
    sysreg_write = wr;
    sysreg_addr  = addr;
    sysreg_wdata = wd;
    tick();
    sysreg_req   = 1'b0;
    chk(sysreg_rdata, exp_rd);
    chk(sysreg_fault, exp_flt);
  endtask : sra

  task automatic rfw(input logic [3:0] idx, input logic [31:0] d);
    rf_we    = 1'b1;
    rf_widx  = idx;
    rf_wdata = d;
    tick();
    rf_we    = 1'b0;
    rf_ridx  = idx;
    tick();
  endtask : rfw

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask : pulse

  // hang guard, far beyond the roughly 80 cycles used
  initial
  begin
    #20000;
    miscompares++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {nrst, exc_req, nmi_req, scall_req, event_ret, dbg_enter, dbg_return} = '0;
    {secure_enter, secure_exit, priv_instr, cond_we, rf_we, sysreg_req} = '0;
    {irq_level_req, cond_flags, rf_widx, rf_ridx, sysreg_write, sysreg_addr} = '0;
    {event_ret_status, rf_wdata, sysreg_wdata} = '0;
    miscompares = 0;
    cmp_count   = 0;
    seed        = 32'ha39b769d;
    repeat (16) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    tick();
    exp_sr = 32'h00400000;
    chk(status_word, exp_sr);
    chk({sysreg_fault, instr_fault, event_taken}, 32'h0);
    // flags land in the lower half, readable by move-from
    cond_flags = 5'(rnd());
    exp_sr[4:0] = cond_flags;
    pulse(cond_we);
    chk(status_word, exp_sr);
    sra(1'b0, 10'h000, 32'h0, exp_sr, 1'b0);
    sra(1'b0, 10'h004, 32'h0, 32'h0, 1'b0);
    // every register index holds a full word
    for (int i = 0; i < 16; i++)
    begin
      rf_model[i] = rnd();
      rfw(i[3:0], rf_model[i]);
      chk(rf_rdata, rf_model[i]);
    end
    sys_stack = rf_model[13];
    // preemption only by strictly higher priority
    ev(4'b0010, 1'b0, 1'b0, 1'b1, 3'h3);
    ev(4'b0010, 1'b0, 1'b0, 1'b0, 3'h3);
    ev(4'b0011, 1'b0, 1'b0, 1'b0, 3'h3);
    ev(4'b1011, 1'b0, 1'b0, 1'b1, 3'h5);
    ev(4'b1011, 1'b1, 1'b0, 1'b1, 3'h6);
    ev(4'b1011, 1'b1, 1'b1, 1'b1, 3'h7);
    ev(4'b0000, 1'b0, 1'b0, 1'b0, 3'h7);
    // drop to application mode
    event_ret_status = 32'h0;
    pulse(event_ret);
    exp_sr = 32'h0;
    chk(status_word, exp_sr);
    sra(1'b0, 10'h030, 32'h0, 32'h0, 1'b1);
    sra(1'b1, 10'h000, 32'h01c0001f, 32'h0, 1'b0);
    exp_sr = 32'h0000001f;
    chk(status_word, exp_sr);
    priv_instr = 1'b1;
    tick();
    priv_instr = 1'b0;
    chk(instr_fault, 1'b1);
    user_stack = rnd();
    rfw(4'hd, user_stack);
    chk(rf_rdata, user_stack);
    // supervisor call gives back the system stack
    pulse(scall_req);
    chk(status_word[24:22], 3'h1);
    rf_ridx = 4'hd;
    tick();
    chk(rf_rdata, sys_stack);
    exp_sr[24:22] = 3'h1;
    // debug masks all levels, grants access, returns whole
    pulse(dbg_enter);
    chk({status_word[26], status_word[20:17]}, 5'h1f);
    sra(1'b0, 10'h030, 32'h0, exp_sr, 1'b0);
    sra(1'b0, 10'h1b0, 32'h0, 32'h0, 1'b1);
    pulse(dbg_return);
    chk(status_word, exp_sr);
    // secure stack only inside secure state
    sra(1'b1, 10'h1b0, 32'h5a5a0000, 32'h0, 1'b1);
    pulse(secure_enter);
    chk(status_word[31], 1'b1);
    user_stack = rnd();
    sra(1'b1, 10'h1b0, user_stack, 32'h0, 1'b0);
    sra(1'b0, 10'h1b0, 32'h0, user_stack, 1'b0);
    pulse(secure_exit);
    sra(1'b0, 10'h1b0, 32'h0, 32'h0, 1'b1);
    // level zero and level two from supervisor, then a lower one waits
    ev(4'b0001, 1'b0, 1'b0, 1'b1, 3'h2);
    ev(4'b0101, 1'b0, 1'b0, 1'b1, 3'h4);
    ev(4'b0001, 1'b0, 1'b0, 1'b0, 3'h4);
    end_of_test();
  end
endmodule : cmsr_regs_tb

// file: src/cmsr_arb_if.sv
`timescale 1ns/1ps
// request arbitration signals between the core regs and the arbiter
interface cmsr_arb_if;
  import cmsr_pkg::*;
  logic [3:0]    lvl_req;
  logic          exc_req;
  logic          nmi_req;
  logic [31:0]   status;
  cmsr_mode_type win_mode;
  logic          take;

  modport regs (output lvl_req, output exc_req, output nmi_req, output status,
                input win_mode, input take);
  modport arb  (input lvl_req, input exc_req, input nmi_req, input status,
                output win_mode, output take);
endinterface : cmsr_arb_if

// file: src/cmsr_mode_arb.sv
`timescale 1ns/1ps
module cmsr_mode_arb
  import cmsr_pkg::*;
(
  cmsr_arb_if.arb arb
);

  logic [3:0]    lvl_ok;
  cmsr_mode_type cur_mode;

  // ==========================================================
  // masked level requests; global mask gates all levels
  assign lvl_ok   = arb.lvl_req & ~arb.status[CMSR_BIT_LM0 +: 4]
                    & {4{~arb.status[CMSR_BIT_GM]}};
  assign cur_mode = cmsr_mode_type'(arb.status[CMSR_BIT_M0 +: 3]);

  // fixed ranking: nmi, exception, level three down to zero
  always_comb
  begin
    arb.win_mode = CMSR_MODE_APP;
    if (arb.nmi_req)                                       // RL4
      arb.win_mode = CMSR_MODE_NMI;
    else if (arb.exc_req && !arb.status[CMSR_BIT_EM])
      arb.win_mode = CMSR_MODE_EXC;
    else if (lvl_ok[3])
      arb.win_mode = CMSR_MODE_LVL3;
    else if (lvl_ok[2])
      arb.win_mode = CMSR_MODE_LVL2;
    else if (lvl_ok[1])
      arb.win_mode = CMSR_MODE_LVL1;
    else if (lvl_ok[0])
      arb.win_mode = CMSR_MODE_LVL0;
  end

  // strictly higher code only; equal or lower waits
  assign arb.take = (arb.win_mode > cur_mode) && (arb.win_mode > CMSR_MODE_SUP); // RL5

endmodule : cmsr_mode_arb

// file: src/cmsr_pkg.sv
// How it works
// RL1: status word split into two halves
// RL2: lower half holds flags and bits
// RL3: lower half clears to zero on reset
// RL4: nmi, exception, levels three..zero ranked
// RL5: only strictly higher priority preempts
// RL6: application mode blocks privileged resources
// RL7: reset starts in supervisor mode
// RL8: debug state grants full register access; secure registers still need secure state
// RL9: debug entry masks every interrupt level
// RL10: debug return instruction leaves debug state
// RL11: non-secure code denied secure resources
// RL12: sixteen 32-bit registers, counter, link and stack
// RL13: system registers only via move instructions
// RL14: stack pointer banked per context
package cmsr_pkg;

  // ==========================================================
  // status word lower half: condition and control bits
  localparam int unsigned CMSR_BIT_C   = 0;
  localparam int unsigned CMSR_BIT_Z   = 1;
  localparam int unsigned CMSR_BIT_N   = 2;
  localparam int unsigned CMSR_BIT_V   = 3;
  localparam int unsigned CMSR_BIT_Q   = 4;
  localparam int unsigned CMSR_BIT_L   = 5;
  localparam int unsigned CMSR_BIT_T   = 14;
  localparam int unsigned CMSR_BIT_R   = 15;

  // ==========================================================
  // status word upper half: masks, mode and state
  localparam int unsigned CMSR_BIT_GM  = 16;
  localparam int unsigned CMSR_BIT_LM0 = 17;
  localparam int unsigned CMSR_BIT_EM  = 21;
  localparam int unsigned CMSR_BIT_M0  = 22;
  localparam int unsigned CMSR_BIT_DBG = 26;
  localparam int unsigned CMSR_BIT_SEC = 31;

  localparam logic [15:0] CMSR_LOW_RESET = 16'h0000;

  // ==========================================================
  // execution modes; a larger code is a higher priority
  typedef enum logic [2:0] {
    CMSR_MODE_APP  = 3'h0,
    CMSR_MODE_SUP  = 3'h1,
    CMSR_MODE_LVL0 = 3'h2,
    CMSR_MODE_LVL1 = 3'h3,
    CMSR_MODE_LVL2 = 3'h4,
    CMSR_MODE_LVL3 = 3'h5,
    CMSR_MODE_EXC  = 3'h6,
    CMSR_MODE_NMI  = 3'h7
  } cmsr_mode_type;

  // ==========================================================
  // register file indices and stack pointer banks
  localparam logic [3:0] CMSR_IDX_SP = 4'hd;
  localparam logic [3:0] CMSR_IDX_LINK    = 4'he;
  localparam logic [3:0] CMSR_IDX_COUNTER = 4'hf;
  localparam logic [1:0] CMSR_BANK_USER = 2'h0;
  localparam logic [1:0] CMSR_BANK_SYS  = 2'h1;
  localparam logic [1:0] CMSR_BANK_SEC  = 2'h2;

  // ==========================================================
  // system register byte addresses
  localparam logic [9:0] CMSR_SYS_STATUS     = 10'h000;
  localparam logic [9:0] CMSR_SYS_DBG_STATUS = 10'h030;
  localparam logic [9:0] CMSR_SYS_DBG_ADDR   = 10'h050;
  localparam logic [9:0] CMSR_SYS_SEC_LO     = 10'h19c;
  localparam logic [9:0] CMSR_SYS_SEC_HI     = 10'h1bc;
  localparam logic [9:0] CMSR_SYS_SEC_STACK  = 10'h1b0;

endpackage : cmsr_pkg

// file: src/cmsr_regs.sv
`timescale 1ns/1ps
module cmsr_regs
  import cmsr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  irq_level_req,
  input  wire logic        exc_req,
  input  wire logic        nmi_req,
  input  wire logic        scall_req,
  input  wire logic        event_ret,
  input  wire logic [31:0] event_ret_status,
  input  wire logic        dbg_enter,
  input  wire logic        dbg_return,
  input  wire logic        secure_enter,
  input  wire logic        secure_exit,
  input  wire logic        priv_instr,
  input  wire logic        cond_we,
  input  wire logic [4:0]  cond_flags,
  input  wire logic        rf_we,
  input  wire logic [3:0]  rf_widx,
  input  wire logic [31:0] rf_wdata,
  input  wire logic [3:0]  rf_ridx,
  input  wire logic        sysreg_req,
  input  wire logic        sysreg_write,
  input  wire logic [9:0]  sysreg_addr,
  input  wire logic [31:0] sysreg_wdata,
  output logic [31:0]      status_word,
  output logic [31:0]      rf_rdata,
  output logic [31:0]      sysreg_rdata,
  output logic             sysreg_fault,
  output logic             instr_fault,
  output logic             event_taken
);

  cmsr_arb_if arb_bus ();

  logic [31:0]   status_reg;
  logic [31:0]   rsr_dbg_reg;
  logic [31:0]   rar_dbg_reg;
  logic [31:0]   gpr_reg [0:15];
  logic [31:0]   sp_bank_reg [0:2];
  logic [1:0]    bank_sel;
  logic          in_debug;
  logic          in_secure;
  logic          privileged;
  logic          sec_range;
  logic          sys_ok;
  logic          status_wr;
  cmsr_mode_type cur_mode;

  assign status_word = status_reg;

  // ==========================================================
  // context decode
  assign cur_mode   = cmsr_mode_type'(status_reg[CMSR_BIT_M0 +: 3]);
  assign in_debug   = status_reg[CMSR_BIT_DBG];
  assign in_secure  = status_reg[CMSR_BIT_SEC];
  assign privileged = (cur_mode != CMSR_MODE_APP) || in_debug;       // RL6 RL8
  assign sec_range  = (sysreg_addr >= CMSR_SYS_SEC_LO) && (sysreg_addr <= CMSR_SYS_SEC_HI);
  // secure registers need secure state even from debug
  assign sys_ok     = sec_range ? in_secure                           // RL11
                    : (privileged || sysreg_addr == CMSR_SYS_STATUS); // RL6 RL13
  assign status_wr  = sysreg_req && sysreg_write && sys_ok && (sysreg_addr == CMSR_SYS_STATUS);

  // stack pointer bank follows secure state, then mode
  always_comb
  begin
    if (in_secure)                                                    // RL14
      bank_sel = CMSR_BANK_SEC;
    else if (cur_mode == CMSR_MODE_APP)
      bank_sel = CMSR_BANK_USER;
    else
      bank_sel = CMSR_BANK_SYS;
  end

  // ==========================================================
  // arbitration of pending events
  assign arb_bus.lvl_req = irq_level_req;
  assign arb_bus.exc_req = exc_req;
  assign arb_bus.nmi_req = nmi_req;
  assign arb_bus.status  = status_reg;

  cmsr_mode_arb u_arb (
    .arb (arb_bus.arb)
  );

  // ==========================================================
  // status word; debug events outrank mode events, then writes
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      status_reg                       <= '0;                        // RL1
      status_reg[15:0]                 <= CMSR_LOW_RESET;            // RL3
      status_reg[CMSR_BIT_M0 +: 3]     <= CMSR_MODE_SUP;             // RL7
    end
    else if (dbg_enter && !in_debug)
    begin
      status_reg[CMSR_BIT_DBG]         <= 1'b1;
      status_reg[CMSR_BIT_LM0 +: 4]    <= 4'hf;                      // RL9
    end
    else if (dbg_return && in_debug)
      status_reg                       <= rsr_dbg_reg;               // RL10
    else if (arb_bus.take)
      status_reg[CMSR_BIT_M0 +: 3]     <= arb_bus.win_mode;          // RL5
    else if (event_ret && privileged)
      status_reg                       <= event_ret_status;
    else if (scall_req && cur_mode == CMSR_MODE_APP)
      status_reg[CMSR_BIT_M0 +: 3]     <= CMSR_MODE_SUP;
    else if (secure_enter || secure_exit)
      status_reg[CMSR_BIT_SEC]         <= secure_enter;
    else if (status_wr)
    begin
      status_reg[15:0]                 <= sysreg_wdata[15:0];        // RL2
      if (privileged)
        status_reg[31:16]              <= sysreg_wdata[31:16];       // RL6
    end
    else if (cond_we)
      status_reg[CMSR_BIT_Q:CMSR_BIT_C] <= cond_flags;               // RL2
  end

  // debug return state captured on entry, also writable by monitor
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rsr_dbg_reg <= '0;
      rar_dbg_reg <= '0;
    end
    else if (dbg_enter && !in_debug)
    begin
      rsr_dbg_reg <= status_reg;
      rar_dbg_reg <= gpr_reg[CMSR_IDX_COUNTER];
    end
    else if (sysreg_req && sysreg_write && sys_ok)
    begin
      if (sysreg_addr == CMSR_SYS_DBG_STATUS)
        rsr_dbg_reg <= sysreg_wdata;
      else if (sysreg_addr == CMSR_SYS_DBG_ADDR)
        rar_dbg_reg <= sysreg_wdata;
    end
  end

  // ==========================================================
  // register file: shared entries, sp slot unused here
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_gpr
      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
          gpr_reg[gi] <= '0;
        else if (rf_we && rf_widx == 4'(gi) && rf_widx != CMSR_IDX_SP)   // RL12
          gpr_reg[gi] <= rf_wdata;
      end
    end
    // banked stack pointers; secure bank also via system register
    for (gi = 0; gi < 3; gi++)
    begin : g_sp
      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
          sp_bank_reg[gi] <= '0;
        else if (rf_we && rf_widx == CMSR_IDX_SP && bank_sel == 2'(gi))  // RL14
          sp_bank_reg[gi] <= rf_wdata;
        else if (gi == 2 && sysreg_req && sysreg_write && sys_ok
                 && sysreg_addr == CMSR_SYS_SEC_STACK)
          sp_bank_reg[gi] <= sysreg_wdata;                             // RL11
      end
    end
  endgenerate

  // register read, one cycle latency
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      rf_rdata <= '0;
    else if (rf_ridx == CMSR_IDX_SP)
      rf_rdata <= sp_bank_reg[bank_sel];                              // RL14
    else
      rf_rdata <= gpr_reg[rf_ridx];                                   // RL12
  end

  // ==========================================================
  // system register reads and faults; unmapped reads give zero
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sysreg_rdata <= '0;
      sysreg_fault <= 1'b0;
    end
    else
    begin
      sysreg_fault <= sysreg_req && !sys_ok;                          // RL11 RL13
      sysreg_rdata <= '0;
      if (sysreg_req && !sysreg_write && sys_ok)
      begin
        if (sysreg_addr == CMSR_SYS_STATUS)
          sysreg_rdata <= privileged ? status_reg : {16'h0000, status_reg[15:0]}; // RL6
        else if (sysreg_addr == CMSR_SYS_DBG_STATUS)
          sysreg_rdata <= rsr_dbg_reg;                                // RL8
        else if (sysreg_addr == CMSR_SYS_DBG_ADDR)
          sysreg_rdata <= rar_dbg_reg;
        else if (sysreg_addr == CMSR_SYS_SEC_STACK)
          sysreg_rdata <= sp_bank_reg[CMSR_BANK_SEC];
      end
    end
  end

  // restricted instruction trap and event pulse
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      instr_fault <= 1'b0;
      event_taken <= 1'b0;
    end
    else
    begin
      instr_fault <= priv_instr && !privileged;                       // RL6 RL8
      event_taken <= arb_bus.take && !(dbg_enter && !in_debug) && !(dbg_return && in_debug);
    end
  end

  // ==========================================================
  // checks
  logic quiet;
  assign quiet = !dbg_enter && !dbg_return && !event_ret && !scall_req && !status_wr;

  reset_state_a: assert property (@(posedge clk_sys) // RL3
    $past(!nrst) && nrst |-> status_reg[15:0] == 16'h0000
                                && status_reg[CMSR_BIT_M0 +: 3] == CMSR_MODE_SUP)
    else $error("reset state wrong");
  preempt_take_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL5
    arb_bus.take && quiet |=> cur_mode == $past(arb_bus.win_mode) && event_taken)
    else $error("higher request not taken");
  no_lower_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL5
    quiet && cur_mode > CMSR_MODE_SUP && arb_bus.win_mode <= cur_mode |=> $stable(cur_mode))
    else $error("mode preempted by lower priority");
  dbg_mask_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL9
    dbg_enter && !in_debug |=> status_reg[CMSR_BIT_LM0 +: 4] == 4'hf && in_debug)
    else $error("debug entry did not mask levels");
  dbg_exit_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL10
    dbg_return && in_debug && !dbg_enter |=> status_reg == $past(rsr_dbg_reg))
    else $error("debug return failed");
  app_upper_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL6
    status_wr && !privileged && !secure_enter && !secure_exit && !arb_bus.take
      && !dbg_enter && !scall_req
      |=> status_reg[31:16] == $past(status_reg[31:16]))
    else $error("application wrote upper half");
  secure_deny_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL11
    sysreg_req && sec_range && !in_secure |=> sysreg_fault ##1 !sysreg_fault || $past(sysreg_req))
    else $error("secure register reached outside secure state");
  debug_access_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL8
    sysreg_req && in_debug && !sec_range |=> !sysreg_fault)
    else $error("debug access refused");
  sp_bank_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL14
    rf_we && rf_widx == CMSR_IDX_SP && bank_sel == CMSR_BANK_USER
      |=> sp_bank_reg[CMSR_BANK_USER] == $past(rf_wdata))
    else $error("user stack pointer not written");

  irq_cover_c: cover property (@(posedge clk_sys) disable iff (!nrst) event_taken);
  dbg_cover_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    dbg_enter && !in_debug ##[1:20] dbg_return && in_debug);
  sec_cover_c: cover property (@(posedge clk_sys) disable iff (!nrst) sysreg_fault);

endmodule : cmsr_regs
